// *** rtl/ssq_pkg.sv ***
// shared constants, types and conversions for the supply sequencer fault and cascade logic
package ssq_pkg;

	// clock
	localparam int unsigned CLK_PERIOD_NS = 100;

	// capacitor-set delays, in nanoseconds
	localparam int unsigned FIRST_DLY_NS  = 1000000;
	localparam int unsigned OUT_DLY_NS    = 1000000;
	localparam int unsigned SETTLE_DLY_NS = 1000000;
	localparam int unsigned HOLD_DLY_NS   = 1000000;

	// least times round up to whole cycles, never below one
	function automatic int unsigned ns_to_cyc(input int unsigned ns);
		int unsigned c;
		c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
		return (c < 1) ? 1 : c;
	endfunction

	localparam int unsigned FIRST_DLY_CYC  = ns_to_cyc(FIRST_DLY_NS);
	localparam int unsigned OUT_DLY_CYC    = ns_to_cyc(OUT_DLY_NS);
	localparam int unsigned SETTLE_DLY_CYC = ns_to_cyc(SETTLE_DLY_NS);
	localparam int unsigned HOLD_DLY_CYC   = ns_to_cyc(HOLD_DLY_NS);

	// structure
	localparam int unsigned NUM_OUT   = 4;
	localparam int unsigned TIMER_W   = 24;

	// synchronised command and fault-line levels
	typedef struct packed {
		logic rise;
		logic fall_n;
		logic line;
	} ssq_ctl_t;

	localparam ssq_ctl_t CTL_RESET = '{rise: 1'b0, fall_n: 1'b1, line: 1'b1};

	// control states
	typedef enum logic [2:0] {
		ST_HOLD,
		ST_RELEASE,
		ST_AWAIT,
		ST_IDLE,
		ST_UP_DELAY,
		ST_UP_SETTLE,
		ST_UP_DONE,
		ST_DOWN_DELAY
	} ssq_state_t;

endpackage

// *** rtl/ssq_delay_timer.sv ***
// reloadable down-counter that stands in for one capacitor delay
`timescale 1ns/1ps
module ssq_delay_timer #(
	parameter int unsigned         CNT_W       = 24,
	parameter logic [CNT_W-1:0]    RESET_COUNT = '0
) (
	// clock and reset
	input  wire logic              ref_clk,
	input  wire logic              resetn,
	// control
	input  wire logic              load,
	input  wire logic [CNT_W-1:0]  load_value,
	// status
	output logic                   expired
);

	logic [CNT_W-1:0] count;

	// reload on request, else count down to zero and stop
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			count <= RESET_COUNT;
		end else if (load) begin
			count <= load_value;
		end else if (count != '0) begin
			count <= count - 1'b1;
		end
	end

	assign expired = (count == '0);

endmodule // ssq_delay_timer

// *** rtl/ssq_fault_cascade.sv ***
// fault handling, up/down sequencing and cascade control of a four-output sequencer
//
// Operation
// - start in fault states after lockout release
// - internal fault drives error line low
// - external low line forces hold and drive
// - hold waits fault hold time, then release
// - release drives line until rise_request low
// - line high in await moves to idle
// - line held low keeps device in await
// - supply lockout pulls line low, forces fault
// - unexpected command edges are faults
// - power-up enables outputs in turn, delayed
// - chain_complete rises when power-up completes
// - fall_request_n falling starts reverse power-down
// - chain_complete falls a first-output delay after all outputs off
// - power good needs done and supplies ok
// - first-output delay times chain gap both ways
// - per-output delay before next enable
// - per-output delay spaces power-down steps
// - settle window before checking new supply
`timescale 1ns/1ps
module ssq_fault_cascade
	import ssq_pkg::*;
#(
	parameter int unsigned N_OUT          = ssq_pkg::NUM_OUT,
	parameter int unsigned CNT_W          = ssq_pkg::TIMER_W,
	parameter int unsigned FIRST_DLY_CYC  = ssq_pkg::FIRST_DLY_CYC,
	parameter int unsigned OUT_DLY_CYC    = ssq_pkg::OUT_DLY_CYC,
	parameter int unsigned SETTLE_DLY_CYC = ssq_pkg::SETTLE_DLY_CYC,
	parameter int unsigned HOLD_DLY_CYC   = ssq_pkg::HOLD_DLY_CYC
) (
	// clock and reset
	input  wire logic              ref_clk,
	input  wire logic              resetn,
	// sequence commands
	input  wire logic              rise_request,
	input  wire logic              fall_request_n,
	// shared open-drain error line
	input  wire logic              error_line_n_in,
	output logic                   error_line_n_out,
	output logic                   error_line_n_oe,
	// supply monitoring
	input  wire logic [N_OUT-1:0]  monitored_inputs,
	input  wire logic              supply_lockout,
	// supply enables and status
	output logic [N_OUT-1:0]       enable_outputs,
	output logic                   chain_complete,
	output logic                   power_good_indication
);
	import ssq_pkg::*;

	localparam int unsigned IDX_W = $clog2(N_OUT);
	localparam logic [IDX_W-1:0] LAST = IDX_W'(N_OUT - 1);

	// elaboration checks
	if (N_OUT < 2 || N_OUT > 16) begin : g_chk_n
		$error("N_OUT must be 2 to 16");
	end
	if (FIRST_DLY_CYC < 1 || OUT_DLY_CYC < 1 || SETTLE_DLY_CYC < 1 || HOLD_DLY_CYC < 1)
	begin : g_chk_dly
		$error("delay counts must be at least one cycle");
	end
	if (CNT_W < 2 || CNT_W > 31 || HOLD_DLY_CYC >= (1 << CNT_W) || FIRST_DLY_CYC >= (1 << CNT_W)
		|| OUT_DLY_CYC >= (1 << CNT_W) || SETTLE_DLY_CYC >= (1 << CNT_W)) begin : g_chk_w
		$error("CNT_W too small for the delay counts");
	end

	// timer reload value for a state: one less than the cycles a timed state lasts
	function automatic logic [CNT_W-1:0] delay_for(input ssq_state_t st,
		input logic [IDX_W-1:0] i);
		int unsigned c;
		c = 1;
		unique case (st)
			ST_HOLD:       c = HOLD_DLY_CYC;
			ST_UP_DELAY:   c = (i == '0) ? FIRST_DLY_CYC : OUT_DLY_CYC;
			ST_UP_SETTLE:  c = SETTLE_DLY_CYC;
			ST_DOWN_DELAY: c = (i == '0) ? FIRST_DLY_CYC : OUT_DLY_CYC;
			ST_RELEASE, ST_AWAIT, ST_IDLE, ST_UP_DONE: c = 1;
		endcase
		return CNT_W'(c - 1);
	endfunction

	ssq_ctl_t          sync1;
	ssq_ctl_t          sync2;
	ssq_ctl_t          prev;
	ssq_state_t        state;
	ssq_state_t        next_state;
	logic [IDX_W-1:0]  idx;
	logic [IDX_W-1:0]  next_idx;
	logic [N_OUT-1:0]  next_en;
	logic              expired;

	// two-stage synchroniser plus one stage of history for edges
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			sync1 <= CTL_RESET;
			sync2 <= CTL_RESET;
			prev  <= CTL_RESET;
		end else begin
			sync1 <= '{rise: rise_request, fall_n: fall_request_n, line: error_line_n_in};
			sync2 <= sync1;
			prev  <= sync2;
		end
	end

	// edge and level decode on synchronised signals
	wire rise_up   = sync2.rise & ~prev.rise;
	wire rise_dn   = ~sync2.rise & prev.rise;
	wire fall_dn   = ~sync2.fall_n & prev.fall_n;
	wire fall_up   = sync2.fall_n & ~prev.fall_n;
	wire line_low  = ~sync2.line;
	wire in_up     = (state == ST_UP_DELAY) || (state == ST_UP_SETTLE);
	wire in_run    = in_up || (state == ST_UP_DONE) || (state == ST_DOWN_DELAY);

	// outputs that must already be up: all enabled ones except one still settling
	wire [N_OUT-1:0] settling = (state == ST_UP_SETTLE) ? (N_OUT'(1) << idx) : '0;
	wire             uv_fault = in_run && |(enable_outputs & ~settling & ~monitored_inputs);

	// commands arriving where they are not valid
	wire bad_edge = ((state == ST_IDLE) && (rise_dn || fall_dn))
		|| (in_up && (rise_up || rise_dn || fall_dn))
		|| ((state == ST_UP_DONE) && rise_up)
		|| ((state == ST_DOWN_DELAY) && (rise_up || fall_dn || fall_up));

	// any party pulling the line outside the fault states is a fault
	wire ext_fault = (in_run || (state == ST_IDLE)) && line_low;
	wire fault     = uv_fault || bad_edge || ext_fault;
	wire settle_ok = monitored_inputs[idx];

	// control state machine
	always_comb begin
		next_state = state;
		next_idx   = idx;
		next_en    = enable_outputs;
		unique case (state)
			ST_HOLD: begin
				if (expired) begin
					next_state = ST_RELEASE;
				end
			end
			ST_RELEASE: begin
				if (!sync2.rise) begin
					next_state = ST_AWAIT;
				end
			end
			ST_AWAIT: begin
				if (!line_low) begin
					next_state = ST_IDLE;
				end
			end
			ST_IDLE: begin
				if (rise_up) begin
					next_state = ST_UP_DELAY;
					next_idx   = '0;
				end
			end
			ST_UP_DELAY: begin
				if (expired) begin
					next_state      = ST_UP_SETTLE;
					next_en[idx]    = 1'b1;
				end
			end
			ST_UP_SETTLE: begin
				if (expired && settle_ok) begin
					if (idx == LAST) begin
						next_state = ST_UP_DONE;
					end else begin
						next_state = ST_UP_DELAY;
						next_idx   = idx + 1'b1;
					end
				end
			end
			ST_UP_DONE: begin
				if (fall_dn) begin
					next_state    = ST_DOWN_DELAY;
					next_idx      = LAST;
					next_en[LAST] = 1'b0;
				end
			end
			ST_DOWN_DELAY: begin
				if (expired) begin
					if (idx == '0) begin
						next_state = ST_IDLE;
					end else begin
						next_idx          = idx - 1'b1;
						next_en[idx-1'b1] = 1'b0;
					end
				end
			end
		endcase
		// fault entry overrides everything, lockout from every state
		if (supply_lockout || fault || ((state == ST_UP_SETTLE) && expired && !settle_ok)) begin
			next_state = ST_HOLD;
			next_idx   = '0;
			next_en    = '0;
		end
	end

	// restart the delay on every entry, index step or held lockout
	wire timer_load = (next_state != state) || (next_idx != idx) || supply_lockout;

	ssq_delay_timer #(
		.CNT_W       (CNT_W),
		.RESET_COUNT (CNT_W'(HOLD_DLY_CYC - 1))
	) u_timer (
		.ref_clk     (ref_clk),
		.resetn      (resetn),
		.load        (timer_load),
		.load_value  (delay_for(next_state, next_idx)),
		.expired     (expired)
	);

	// state, outputs and line drive, all registered
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			state                 <= ST_HOLD;
			idx                   <= '0;
			enable_outputs        <= '0;
			chain_complete        <= 1'b0;
			power_good_indication <= 1'b0;
			error_line_n_oe       <= 1'b1;
			error_line_n_out      <= 1'b0;
		end else begin
			state                 <= next_state;
			idx                   <= next_idx;
			enable_outputs        <= next_en;
			chain_complete        <= (next_state == ST_UP_DONE) || (next_state == ST_DOWN_DELAY);
			power_good_indication <= (state == ST_UP_DONE) && (&monitored_inputs);
			error_line_n_oe       <= (next_state == ST_HOLD) || (next_state == ST_RELEASE);
			error_line_n_out      <= !((next_state == ST_HOLD) || (next_state == ST_RELEASE));
		end
	end

	// checks
	a_hold_drives_line: assert property (@(posedge ref_clk) disable iff (!resetn)
		(state == ST_HOLD || state == ST_RELEASE) |-> error_line_n_oe && !error_line_n_out)
		else $error("line not driven low in fault hold or release");
	a_release_waits_rise: assert property (@(posedge ref_clk) disable iff (!resetn)
		(state == ST_RELEASE && sync2.rise && !supply_lockout) |=> state == ST_RELEASE)
		else $error("release left while rise_request high");
	a_release_frees_line: assert property (@(posedge ref_clk) disable iff (!resetn)
		(state == ST_RELEASE && !sync2.rise && !supply_lockout)
		|=> state == ST_AWAIT && !error_line_n_oe)
		else $error("line not released after rise_request low");
	a_await_to_idle: assert property (@(posedge ref_clk) disable iff (!resetn)
		(state == ST_AWAIT && !line_low && !supply_lockout) |=> state == ST_IDLE)
		else $error("await did not move to idle on line high");
	a_await_line_low: assert property (@(posedge ref_clk) disable iff (!resetn)
		(state == ST_AWAIT && line_low && !supply_lockout) |=> state == ST_AWAIT)
		else $error("await left while line held low");
	a_lockout_pulls_line: assert property (@(posedge ref_clk) disable iff (!resetn)
		supply_lockout |=> state == ST_HOLD && error_line_n_oe && enable_outputs == '0)
		else $error("lockout did not force fault");
	a_bad_edge_fault: assert property (@(posedge ref_clk) disable iff (!resetn)
		(state == ST_UP_DONE && rise_up) |=> state == ST_HOLD ##1 error_line_n_oe)
		else $error("unexpected rise edge not treated as fault");
	a_enable_one_step: assert property (@(posedge ref_clk) disable iff (!resetn)
		(enable_outputs != $past(enable_outputs) && enable_outputs != '0)
		|-> $countones(enable_outputs ^ $past(enable_outputs)) == 1)
		else $error("more than one enable changed at once");
	a_chain_rises: assert property (@(posedge ref_clk) disable iff (!resetn)
		(state == ST_UP_SETTLE && expired && idx == LAST && next_state == ST_UP_DONE)
		|=> chain_complete && enable_outputs == '1)
		else $error("chain_complete not raised at end of power-up");
	a_down_starts: assert property (@(posedge ref_clk) disable iff (!resetn)
		(state == ST_UP_DONE && next_state == ST_DOWN_DELAY)
		|=> !enable_outputs[LAST] && chain_complete)
		else $error("power-down did not drop the last output first");
	a_chain_falls_off: assert property (@(posedge ref_clk) disable iff (!resetn)
		$fell(chain_complete) |-> enable_outputs == '0)
		else $error("chain_complete fell with outputs still on");
	a_power_good_cause: assert property (@(posedge ref_clk) disable iff (!resetn)
		power_good_indication |-> $past(state) == ST_UP_DONE && (&$past(monitored_inputs)))
		else $error("power good without completed sequence");

endmodule // ssq_fault_cascade

// *** testbench/ssq_far_side.sv ***
// far-side model: another party that pulls the shared error line
`timescale 1ns/1ps
module ssq_far_side (
	// clock
	input  wire logic       ref_clk,
	// pulse command from the bench
	input  wire logic       pull_go,
	input  wire logic [7:0] pull_len,
	// open-drain pull, high while pulling low
	output logic            pull_oe
);
	logic [7:0] left;

	initial left = 8'h00;

	// holds the line low for pull_len cycles, then lets it go
	always @(posedge ref_clk) begin
		if (pull_go) begin
			left <= pull_len;
		end else if (left != 8'h00) begin
			left <= left - 8'h01;
		end
	end

	// pull stands while cycles remain
	assign pull_oe = (left != 8'h00);
endmodule // ssq_far_side

// *** testbench/tb_ssq_fault_cascade.sv ***
// self-checking bench for the sequencer fault and cascade logic
`timescale 1ns/1ps
module tb_ssq_fault_cascade;
	import ssq_pkg::*;
	localparam int unsigned F = 4;
	localparam int unsigned O = 3;
	localparam int unsigned S = 5;
	localparam int unsigned H = 6;
	// which design output wait_bit watches
	localparam bit SEL_OE = 1'b0;
	localparam bit SEL_CC = 1'b1;
	logic       ref_clk, resetn, rise_request, fall_request_n, supply_lockout, pull_go;
	logic       error_line_n_in, error_line_n_out, error_line_n_oe, far_oe;
	logic       chain_complete, power_good_indication;
	logic [7:0] pull_len;
	logic [3:0] monitored_inputs, enable_outputs;
	int         n_fail, checks_done, cyc, seed, t, kind, k;

	// design under test with short delays
	ssq_fault_cascade #(.FIRST_DLY_CYC(F), .OUT_DLY_CYC(O), .SETTLE_DLY_CYC(S),
		.HOLD_DLY_CYC(H)) ssq_fault_cascade_inst (.ref_clk(ref_clk), .resetn(resetn),
		.rise_request(rise_request), .fall_request_n(fall_request_n),
		.error_line_n_in(error_line_n_in), .error_line_n_out(error_line_n_out),
		.error_line_n_oe(error_line_n_oe), .monitored_inputs(monitored_inputs),
		.supply_lockout(supply_lockout), .enable_outputs(enable_outputs),
		.chain_complete(chain_complete), .power_good_indication(power_good_indication));

	// neighbour pulling the shared line
	ssq_far_side ssq_far_side_inst (.ref_clk(ref_clk), .pull_go(pull_go),
		.pull_len(pull_len), .pull_oe(far_oe));

	// wired-AND of the open-drain line with pull-up
	assign error_line_n_in = !(error_line_n_oe && !error_line_n_out) && !far_oe;

	// clock
	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end

	// hang guard
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc >= 20000) begin
			n_fail++;
			end_sim();
		end
	end

	task automatic check(input bit ok, input string msg);
		checks_done++;
		if (!ok) begin
			n_fail++;
			$display("mismatch t=%0t %s", $time, msg);
		end
	endtask

	task automatic step(input int n);
		repeat (n) @(negedge ref_clk);
	endtask

	task automatic wait_en(input logic [3:0] v, output int c);
		c = 0;
		while (enable_outputs !== v && c < 300) begin
			step(1);
			c++;
		end
	endtask

	task automatic wait_bit(input bit sel, input logic v, output int c);
		c = 0;
		while ((sel ? chain_complete : error_line_n_oe) !== v && c < 300) begin
			step(1);
			c++;
		end
	endtask

	// leave the fault states and settle in idle
	task automatic recover();
		int c;
		rise_request = 1'b0;
		wait_bit(SEL_OE, 1'b0, c);
		check(c < 300, "line never released");
		step(8);
	endtask

	task automatic power_up();
		int c;
		rise_request = 1'b1;
		wait_en(4'h1, c);
		check(c >= F + 2 && c <= F + 5, "first enable delay");
		for (int i = 1; i < 4; i++) begin
			wait_en(4'hF >> (3 - i), c);
			check(c == S + O, "enable step spacing");
		end
		wait_bit(SEL_CC, 1'b1, c);
		check(c == S && power_good_indication === 1'b0, "chain_complete timing");
		step(1);
		check(power_good_indication === 1'b1, "power good missing");
	endtask

	task automatic power_down();
		int c;
		rise_request = 1'b0; // joined control pins drop together
		fall_request_n = 1'b0;
		wait_en(4'h7, c);
		check(c >= 2 && c <= 5, "power-down start");
		for (int i = 2; i >= 0; i--) begin
			wait_en(4'hF >> (4 - i), c);
			check(c == O && chain_complete === 1'b1, "power-down spacing");
		end
		wait_bit(SEL_CC, 1'b0, c);
		check(c == F, "chain_complete fall delay");
		fall_request_n = 1'b1;
		step(4);
	endtask

	task automatic end_sim();
		$display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// main sequence
	initial begin
		seed = 32'hc24e913d;
		{n_fail, checks_done, cyc} = '0;
		resetn = 1'b0;
		rise_request = 1'b1;
		fall_request_n = 1'b1;
		supply_lockout = 1'b0;
		monitored_inputs = 4'hF;
		pull_go = 1'b0;
		pull_len = 8'h00;
		step(12);
		resetn = 1'b1;
		step(1);
		check(error_line_n_oe === 1'b1 && error_line_n_out === 1'b0, "no fault start");
		step(H + 8);
		check(error_line_n_oe === 1'b1, "line freed while rise high");
		rise_request = 1'b0;
		wait_bit(SEL_OE, 1'b0, t);
		check(t <= 4, "line not freed after rise low");
		step(6);
		power_up();
		power_down();
		// external pulse while powered up
		power_up();
		pull_go = 1'b1;
		pull_len = 8'h02;
		step(1);
		pull_go = 1'b0;
		wait_bit(SEL_OE, 1'b1, t);
		check(t <= 5 && enable_outputs === 4'h0 && chain_complete === 1'b0, "no fault");
		rise_request = 1'b0;
		wait_bit(SEL_OE, 1'b0, t);
		check(t >= H - 1 && t <= H + 4, "fault hold length");
		step(8);
		// line held low: stays waiting
		pull_go = 1'b1;
		pull_len = 8'h3C;
		step(1);
		pull_go = 1'b0;
		step(H + 10);
		rise_request = 1'b1;
		step(6);
		rise_request = 1'b0;
		step(10);
		check(enable_outputs === 4'h0 && error_line_n_oe === 1'b0, "left wait state");
		step(40);
		power_up();
		power_down();
		// rise falling after power-up is legal, rising again is a fault
		power_up();
		rise_request = 1'b0;
		step(4);
		check(chain_complete === 1'b1 && error_line_n_oe === 1'b0, "legal rise fall faulted");
		rise_request = 1'b1;
		wait_bit(SEL_OE, 1'b1, t);
		check(t <= 5 && enable_outputs === 4'h0, "stray rise edge not a fault");
		recover();
		// random fault causes
		for (int n = 0; n < 6; n++) begin
			kind = $unsigned($random(seed)) % 3;
			k = $unsigned($random(seed)) % 4;
			if (kind == 0) begin
				supply_lockout = 1'b1;
				step(k + 1);
				supply_lockout = 1'b0;
				check(error_line_n_oe === 1'b1 && error_line_n_out === 1'b0, "lockout");
			end else if (kind == 1) begin
				fall_request_n = 1'b0;
				wait_bit(SEL_OE, 1'b1, t);
				check(t <= 5, "stray command edge not a fault");
				fall_request_n = 1'b1;
			end else begin
				monitored_inputs = 4'hF & ~(4'h1 << k);
				rise_request = 1'b1;
				wait_en(4'hF >> (3 - k), t);
				step(S - 1);
				check(error_line_n_oe === 1'b0, "supply checked inside settle");
				wait_bit(SEL_OE, 1'b1, t);
				check(t <= 3 && enable_outputs === 4'h0, "supply fault");
				monitored_inputs = 4'hF;
			end
			recover();
		end
		power_up();
		power_down();
		end_sim();
	end
endmodule // tb_ssq_fault_cascade
